// ==== spimss_defs.vh ====
// Constants shared by the serial peripheral shifter and its output buffer
`ifndef SPIMSS_DEFS_VH
`define SPIMSS_DEFS_VH
`define SPIMSS_EDGES_LAST 5'h10
`define SPIMSS_EDGE_ONE 5'h01
`define SPIMSS_EDGE_ZERO 5'h00
`define SPIMSS_TXE_RST 1'b1
`define SPIMSS_RXF_RST 1'b0
`define SPIMSS_BYTE_RST 8'h00
`define SPIMSS_DIV_ZERO 10'h000
`define SPIMSS_PIN_RST 4'hF
`define SPIMSS_PIN_SCLK 0
`define SPIMSS_PIN_MOSI 1
`define SPIMSS_PIN_MISO 2
`define SPIMSS_PIN_SSN 3
`define SPIMSS_CNT_ZERO 2'h0
`define SPIMSS_CNT_ONE 2'h1
`define SPIMSS_CNT_TWO 2'h2
`endif

// ==== spimss_buf.v ====
// Two-entry buffer with valid and ready on both sides
`timescale 1ns/10ps
`include "spimss_defs.vh"
module spimss_buf #(
  parameter W = 8
) (
  // Clock and reset
  input wire i_clock,
  input wire i_rst,
  // Filling side
  input wire i_in_valid,
  input wire [W-1:0] i_in_data,
  output wire o_in_ready,
  // Draining side
  output wire o_out_valid,
  output wire [W-1:0] o_out_data,
  input wire i_out_ready
);
  reg [W-1:0] head_r;
  reg [W-1:0] tail_r;
  reg [1:0] cnt_r;
  wire push;
  wire pop;

  assign o_in_ready = (cnt_r != `SPIMSS_CNT_TWO);
  assign o_out_valid = (cnt_r != `SPIMSS_CNT_ZERO);
  assign o_out_data = head_r;
  assign push = i_in_valid & o_in_ready;
  assign pop = o_out_valid & i_out_ready;

  always @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      head_r <= {W{1'b0}};
      tail_r <= {W{1'b0}};
      cnt_r <= `SPIMSS_CNT_ZERO;
    end else begin
      case ({push, pop})
        2'b10: begin
          if (cnt_r == `SPIMSS_CNT_ZERO) begin
            head_r <= i_in_data;
          end else begin
            tail_r <= i_in_data;
          end
          cnt_r <= cnt_r + `SPIMSS_CNT_ONE;
        end
        2'b01: begin
          head_r <= tail_r;
          cnt_r <= cnt_r - `SPIMSS_CNT_ONE;
        end
        2'b11: begin
          if (cnt_r == `SPIMSS_CNT_ONE) begin
            head_r <= i_in_data;
          end else begin
            head_r <= tail_r;
            tail_r <= i_in_data;
          end
        end
        default: begin
          cnt_r <= cnt_r;
        end
      endcase
    end
  end
endmodule

// ==== spimss_core.v ====
// Master or slave serial peripheral shifter with double buffering
// Overview of operation
// RL1: only the master starts a transfer; shifting swaps both shift registers
// RL2: master drives serial clock out; selected slave takes it as input
// RL3: the master selects a slave by holding its select low
// RL4: master: clock to clock pin, shifter out to MOSI, in from MISO
// RL5: slave: clock from pin, shifter out to MISO, in from MOSI
// RL6: bus clock feeds a prescaler dividing by 1 through 8
// RL7: rate select further divides by powers of two, 2 to 256
// RL8: a write while transmit empty queues; free shifter loads and starts
// RL9: data sampled on one clock edge, shifted half a cycle later
// RL10: after eight clock cycles the byte goes to receive buffer, full set
// RL11: a queued byte at transfer end loads at once, empty flag set
// RL12: most significant bit first unless the LSB-first enable is set
// RL13: a slave's select must be low before and throughout a transfer
// RL14: phase 0 needs select high between transfers; phase 1 need not
// RL15: one queued transmit byte and one held receive byte; code holds up to three received bytes (two in the output buffer)
// RL16: the received byte must be taken before the next transfer ends
// RL17: on overrun the new byte is dropped silently, old byte kept
// RL18: polarity inverts the clock, phase picks one of two timings
// RL19: with the enable low all four pins are released
// RL20: after reset transmit empty set, receive full clear, no transfer
// RL21: clock period is prescale divisor times rate divisor
`timescale 1ns/10ps
`include "spimss_defs.vh"
module spimss_core #(
  parameter DW = 8,
  parameter CW = 10
) (
  // Clock and reset
  input wire i_clock,
  input wire i_rst,
  // Configuration
  input wire i_block_enable,
  input wire i_master_mode,
  input wire i_cpol,
  input wire i_cpha,
  input wire i_lsb_first_enable,
  input wire [2:0] i_prescale_select,
  input wire [2:0] i_rate_divide_select,
  // Transmit data register
  input wire i_tx_write,
  input wire [DW-1:0] i_tx_data,
  output wire o_tx_buffer_empty_flag,
  // Receive stream
  output wire o_rx_buffer_full_flag,
  output wire o_rx_valid,
  output wire [DW-1:0] o_rx_data,
  input wire i_rx_ready,
  output wire o_busy,
  // Serial clock pin
  input wire i_serial_clock_pin,
  output wire o_serial_clock_pin,
  output wire o_serial_clock_pin_oe,
  // Master out pin
  input wire i_master_out_pin,
  output wire o_master_out_pin,
  output wire o_master_out_pin_oe,
  // Master in pin
  input wire i_master_in_pin,
  output wire o_master_in_pin,
  output wire o_master_in_pin_oe,
  // Slave select
  input wire i_slave_select_n
);
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function [CW-1:0] half_limit;
    input [2:0] pre;
    input [2:0] sel;
    reg [CW:0] h;
    begin
      h = ({{(CW-2){1'b0}}, pre} + 1'b1) << sel;
      half_limit = h[CW-1:0] - 1'b1;
    end
  endfunction

  function [DW-1:0] shift_in;
    input [DW-1:0] sh;
    input lsbf;
    input b;
    begin
      if (lsbf) begin
        shift_in = {b, sh[DW-1:1]};
      end else begin
        shift_in = {sh[DW-2:0], b};
      end
    end
  endfunction

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  // A change counts only once stages two and three agree
  reg [3:0] s1_r;
  reg [3:0] s2_r;
  reg [3:0] s3_r;
  reg [3:0] pin_r;
  integer k;
  always @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      s1_r <= `SPIMSS_PIN_RST;
      s2_r <= `SPIMSS_PIN_RST;
      s3_r <= `SPIMSS_PIN_RST;
      pin_r <= `SPIMSS_PIN_RST;
    end else begin
      s1_r <= {i_slave_select_n, i_master_in_pin, i_master_out_pin,
               i_serial_clock_pin};
      s2_r <= s1_r;
      s3_r <= s2_r;
      for (k = 0; k < 4; k = k + 1) begin
        if (s2_r[k] == s3_r[k]) begin
          pin_r[k] <= s3_r[k];
        end
      end
    end
  end

  wire sclk_in = pin_r[`SPIMSS_PIN_SCLK];
  wire selected = i_block_enable & ~i_master_mode &
                  ~pin_r[`SPIMSS_PIN_SSN];
  // Pin that feeds the shifter input in each role
  wire data_in = i_master_mode ? pin_r[`SPIMSS_PIN_MISO] :
                 pin_r[`SPIMSS_PIN_MOSI]; // see RL4 see RL5

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  reg tx_empty_r;
  reg [DW-1:0] tx_buf_r;
  reg [DW-1:0] sh_r;
  reg [DW-1:0] rx_buf_r;
  reg rx_full_r;
  reg busy_r;
  reg [4:0] edge_r;
  reg [CW-1:0] div_r;
  reg sck_r;
  reg samp_r;
  reg sclk_prev_r;
  reg ssn_prev_r;

  // ----------------------------------------------------------------
  // Edge generation
  // ----------------------------------------------------------------
  wire div_hit = (div_r == half_limit(i_prescale_select,
                                      i_rate_divide_select));
  wire m_tick = i_master_mode & busy_r & div_hit; // see RL21
  // The slave sees the clock a few bus cycles late through the
  // synchroniser, so the link rate must stay well below the bus rate
  wire s_tick = selected & busy_r & (sclk_in != sclk_prev_r); // see RL2
  wire tick = m_tick | s_tick;
  wire [4:0] edge_n = edge_r + `SPIMSS_EDGE_ONE;
  // Odd edges sample in phase 0, even edges in phase 1
  wire samp_edge = tick & (edge_n[0] ^ i_cpha); // see RL18
  wire shift_edge = tick & ~(edge_n[0] ^ i_cpha);
  wire last_edge = tick & (edge_n == `SPIMSS_EDGES_LAST);
  // Final bit comes straight from the pin in phase 1
  wire last_bit = i_cpha ? data_in : samp_r;
  wire [DW-1:0] rx_word = shift_in(sh_r, i_lsb_first_enable, last_bit);

  // Start a transfer: master when a byte waits, slave when selected
  wire ss_fell = ssn_prev_r & ~pin_r[`SPIMSS_PIN_SSN];
  wire m_start = i_block_enable & i_master_mode & ~tx_empty_r &
                 (~busy_r | last_edge); // see RL1 see RL11
  wire s_start = selected & ((~busy_r & (ss_fell | i_cpha)) |
                 (last_edge & i_cpha)); // see RL14 see RL13
  wire start = m_start | s_start;
  wire load_tx = start & ~tx_empty_r; // see RL8
  wire s_abort = ~i_master_mode & busy_r & ~selected; // see RL13

  // Receive buffer hand-off to the output buffer
  wire fifo_in_ready;
  wire pop = rx_full_r & fifo_in_ready;
  wire done = last_edge & busy_r; // see RL10

  // ----------------------------------------------------------------
  // Transmit buffer
  // ----------------------------------------------------------------
  always @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      tx_empty_r <= `SPIMSS_TXE_RST; // see RL20
      tx_buf_r <= `SPIMSS_BYTE_RST;
    end else if (load_tx) begin
      tx_empty_r <= 1'b1; // see RL8 see RL11
    end else if (i_tx_write & tx_empty_r) begin
      tx_empty_r <= 1'b0; // see RL15
      tx_buf_r <= i_tx_data;
    end
  end

  // ----------------------------------------------------------------
  // Shifter and bit-rate divider
  // ----------------------------------------------------------------
  always @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      busy_r <= 1'b0; // see RL20
      edge_r <= `SPIMSS_EDGE_ZERO;
      div_r <= `SPIMSS_DIV_ZERO;
      sck_r <= 1'b0;
      samp_r <= 1'b0;
      sh_r <= `SPIMSS_BYTE_RST;
      sclk_prev_r <= 1'b0;
      ssn_prev_r <= 1'b1;
    end else begin
      sclk_prev_r <= sclk_in;
      ssn_prev_r <= pin_r[`SPIMSS_PIN_SSN];
      if (~i_block_enable | s_abort) begin
        busy_r <= 1'b0;
        edge_r <= `SPIMSS_EDGE_ZERO;
        sck_r <= 1'b0;
        div_r <= `SPIMSS_DIV_ZERO;
      end else if (start) begin
        busy_r <= 1'b1;
        edge_r <= `SPIMSS_EDGE_ZERO;
        sck_r <= 1'b0;
        div_r <= `SPIMSS_DIV_ZERO;
        // With nothing queued the slave sends its last received byte
        // From idle the shifter already holds the last received byte
        if (load_tx) begin
          sh_r <= tx_buf_r;
        end else begin
          sh_r <= busy_r ? rx_word : sh_r;
        end
      end else if (busy_r) begin
        if (div_hit | ~i_master_mode) begin
          div_r <= `SPIMSS_DIV_ZERO; // see RL6 see RL7
        end else begin
          div_r <= div_r + 1'b1;
        end
        if (tick) begin
          edge_r <= edge_n;
          sck_r <= ~sck_r;
        end
        if (samp_edge) begin
          samp_r <= data_in; // see RL9
        end
        if (shift_edge & (edge_n != `SPIMSS_EDGE_ONE | ~i_cpha)) begin
          sh_r <= shift_in(sh_r, i_lsb_first_enable, samp_r); // see RL9
        end
        if (last_edge) begin
          busy_r <= 1'b0;
          sh_r <= rx_word;
          edge_r <= `SPIMSS_EDGE_ZERO;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Receive buffer
  // ----------------------------------------------------------------
  always @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      rx_full_r <= `SPIMSS_RXF_RST; // see RL20
      rx_buf_r <= `SPIMSS_BYTE_RST;
    end else begin
      // A byte landing while full and not drained is dropped silently
      if (done & (~rx_full_r | pop)) begin
        rx_buf_r <= rx_word; // see RL17
      end
      // Setting wins over the drain in the same cycle
      rx_full_r <= (rx_full_r & ~pop) | done; // see RL15 see RL16
    end
  end

  spimss_buf #(
    .W(DW)
  ) u_rx_buf (
    .i_clock(i_clock),
    .i_rst(i_rst),
    .i_in_valid(rx_full_r),
    .i_in_data(rx_buf_r),
    .o_in_ready(fifo_in_ready),
    .o_out_valid(o_rx_valid),
    .o_out_data(o_rx_data),
    .i_out_ready(i_rx_ready)
  );

  // ----------------------------------------------------------------
  // Pin multiplexing
  // ----------------------------------------------------------------
  wire out_bit = i_lsb_first_enable ? sh_r[0] : sh_r[DW-1]; // see RL12
  wire m_en = i_block_enable & i_master_mode;
  reg out_r;
  // Registered so the last bit holds one bus cycle past the final edge;
  // the returning data needs several bus cycles per half period anyway
  always @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      out_r <= 1'b0;
    end else begin
      out_r <= out_bit; // see RL9
    end
  end
  assign o_serial_clock_pin = i_cpol ^ sck_r; // see RL18 see RL4
  assign o_serial_clock_pin_oe = m_en; // see RL2 see RL19
  assign o_master_out_pin = out_r; // see RL4
  assign o_master_out_pin_oe = m_en; // see RL19
  assign o_master_in_pin = out_r; // see RL5
  assign o_master_in_pin_oe = selected; // see RL5 see RL19
  assign o_tx_buffer_empty_flag = tx_empty_r;
  assign o_rx_buffer_full_flag = rx_full_r;
  assign o_busy = busy_r;
endmodule

// ==== spimss_core_props.sv ====
// Concurrent checks on the ports of the serial peripheral shifter
`timescale 1ns/10ps
module spimss_core_props #(
  parameter DW = 8
) (
  // Clock, reset and controls
  input wire i_clock,
  input wire i_rst,
  input wire i_block_enable,
  input wire i_master_mode,
  input wire i_cpol,
  input wire [2:0] i_prescale_select,
  input wire [2:0] i_rate_divide_select,
  input wire i_tx_write,
  input wire i_rx_ready,
  // Watched outputs
  input wire o_tx_buffer_empty_flag,
  input wire o_rx_buffer_full_flag,
  input wire o_rx_valid,
  input wire [DW-1:0] o_rx_data,
  input wire o_busy,
  input wire o_serial_clock_pin,
  input wire o_serial_clock_pin_oe,
  input wire o_master_out_pin_oe,
  input wire o_master_in_pin_oe
);
  default clocking @(posedge i_clock);
  endclocking
  default disable iff (i_rst);
  // ----------------------------------------
  // Half period counter
  // ----------------------------------------
  reg sck_r;
  reg [10:0] run_r;
  reg [5:0] nedg_r;
  wire chg = o_serial_clock_pin != sck_r;
  wire [10:0] half = ({8'h00, i_prescale_select} + 11'h001)
    << i_rate_divide_select;
  always @(posedge i_clock) begin
    sck_r <= o_serial_clock_pin;
  end
  // First edge of each byte is skipped: its lead-in is not a half period
  always @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      run_r <= 11'h001;
      nedg_r <= 6'h00;
    end else begin
      run_r <= (chg || !o_busy) ? 11'h001 : run_r + 11'h001;
      nedg_r <= o_busy ? nedg_r + {5'h00, chg} : 6'h00;
    end
  end
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  sequence s_take;
    i_tx_write && o_tx_buffer_empty_flag;
  endsequence
  sequence s_load;
    !o_tx_buffer_empty_flag ##1 (o_busy && o_tx_buffer_empty_flag);
  endsequence
  chk_reset_state:
    assert property ($fell(i_rst) |-> o_tx_buffer_empty_flag
      && !o_rx_buffer_full_flag && !o_busy && !o_rx_valid)
    else $error("bad state after reset");
  chk_write_take:
    assert property (s_take |=> !o_tx_buffer_empty_flag)
    else $error("write not queued");
  chk_load_start:
    assert property (s_take ##0 (!o_busy && i_block_enable
      && i_master_mode) |=> s_load)
    else $error("queued byte did not start");
  chk_bit_period:
    assert property (chg && o_busy && o_serial_clock_pin_oe
      && nedg_r[3:0] != 4'h0
      |-> run_r == half)
    else $error("wrong serial clock half period");
  chk_end_full:
    assert property ($fell(o_busy) && i_block_enable
      && $past(i_block_enable) |-> ##[0:1] o_rx_buffer_full_flag)
    else $error("receive full not set");
  chk_idle_level:
    assert property (!o_busy && o_serial_clock_pin_oe && $stable(i_cpol)
      |-> o_serial_clock_pin == i_cpol)
    else $error("idle clock level wrong");
  chk_pins_off:
    assert property (!i_block_enable [*2] |-> !o_serial_clock_pin_oe
      && !o_master_out_pin_oe && !o_master_in_pin_oe)
    else $error("pins driven while disabled");
  chk_master_pins:
    assert property ((i_block_enable && i_master_mode) [*2]
      |-> o_serial_clock_pin_oe && o_master_out_pin_oe
      && !o_master_in_pin_oe)
    else $error("master pin routing wrong");
  chk_rx_hold:
    assert property (o_rx_valid && !i_rx_ready
      |=> o_rx_valid && $stable(o_rx_data))
    else $error("receive word lost while stalled");
endmodule
bind spimss_core spimss_core_props #(.DW(DW)) chk (.*);

// ==== spimss_peer.sv ====
// Behavioural far-side slave device for the serial peripheral shifter
`timescale 1ns/10ps
module spimss_peer (
  // Serial lines
  input wire i_sck,
  input wire i_mosi,
  output reg o_miso,
  // Format
  input wire i_cpol,
  input wire i_cpha,
  input wire i_lsb
);
  reg [7:0] sr = 8'h00;
  // Rises on the sampling edge of whichever of the four formats is set
  wire samp = i_sck ^ i_cpol ^ i_cpha;
  initial o_miso = 1'b1;
  always @(posedge samp) begin
    sr <= i_lsb ? {i_mosi, sr[7:1]} : {sr[6:0], i_mosi};
  end
  // Output moves half a clock after the sample, so it never races it
  always @(negedge samp) begin
    o_miso <= i_lsb ? sr[0] : sr[7];
  end
endmodule

// ==== spimss_core_tb_top.sv ====
// Self-checking bench for the serial peripheral shifter as master and as slave
`timescale 1ns/10ps
module spimss_core_tb_top;
  reg i_clock = 1'b0;
  reg i_rst = 1'b1;
  reg en = 1'b0, cpol = 1'b0, cpha = 1'b0, lsb = 1'b0;
  reg wr = 1'b0, rdy = 1'b0;
  reg mst = 1'b1, ssn = 1'b1, msck = 1'b1, mmosi = 1'b1;
  reg [2:0] pre = 3'h1, sel = 3'h1;
  reg [7:0] wd = 8'h00, k;
  integer errors = 0, tests_run = 0;
  wire txe, rxf, rxv, busy, sco, scoe, mo, moe, mioe, miso, mio;
  wire [7:0] rxd;
  // Released lines idle high until the bench plays master; then the clock returns high but the data line keeps its last bit
  wire sck = scoe ? sco : msck;
  wire mosi = moe ? mo : mmosi;
  spimss_core dut (.i_clock(i_clock), .i_rst(i_rst), .i_block_enable(en),
    .i_master_mode(mst), .i_cpol(cpol), .i_cpha(cpha),
    .i_lsb_first_enable(lsb), .i_prescale_select(pre),
    .i_rate_divide_select(sel), .i_tx_write(wr), .i_tx_data(wd),
    .o_tx_buffer_empty_flag(txe), .o_rx_buffer_full_flag(rxf),
    .o_rx_valid(rxv), .o_rx_data(rxd), .i_rx_ready(rdy), .o_busy(busy),
    .i_serial_clock_pin(sck), .o_serial_clock_pin(sco),
    .o_serial_clock_pin_oe(scoe), .i_master_out_pin(mosi),
    .o_master_out_pin(mo), .o_master_out_pin_oe(moe),
    .i_master_in_pin(miso), .o_master_in_pin(mio),
    .o_master_in_pin_oe(mioe),
    .i_slave_select_n(ssn));
  spimss_peer peer (.i_sck(sck), .i_mosi(mosi), .o_miso(miso),
    .i_cpol(cpol), .i_cpha(cpha), .i_lsb(lsb));
  initial forever #5 i_clock = ~i_clock;
  task chk(input [7:0] got, input [7:0] exp);
    begin
      tests_run = tests_run + 1;
      if (got !== exp) begin
        errors = errors + 1;
        $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task test_done;
    begin
      if (errors == 0 && tests_run > 0)
        $display("RESULT: PASS");
      else
        $display("RESULT: FAIL");
      $finish;
    end
  endtask
  task put(input [7:0] d);
    begin
      wd = d;
      wr = 1'b1;
      @(negedge i_clock);
      wr = 1'b0;
    end
  endtask
  task wait_idle;
    integer n;
    begin
      n = 0;
      while (busy !== 1'b0 || txe !== 1'b1) begin
        @(negedge i_clock);
        n = n + 1;
        if (n > 20000) begin
          errors = errors + 1;
          test_done;
        end
      end
      repeat (4) @(negedge i_clock);
    end
  endtask
  task pop(input [7:0] e);
    begin
      chk({7'h00, rxv}, 8'h01);
      chk(rxd, e);
      rdy = 1'b1;
      @(negedge i_clock);
      rdy = 1'b0;
      @(negedge i_clock);
    end
  endtask
  task cfg(input [2:0] p, input [2:0] s, input [2:0] f, input [7:0] v);
    begin
      pre = p;
      sel = s;
      {cpol, cpha, lsb} = f;
      repeat (8) @(negedge i_clock);
      peer.sr = v;
      peer.o_miso = lsb ? v[0] : v[7];
    end
  endtask
  task t_reset;
    begin
      chk({4'h0, txe, rxf, busy, rxv}, 8'h08);
    end
  endtask
  // Four formats, both bit orders, and a spread of divisors
  task t_formats;
    for (k = 8'h00; k < 8'h05; k = k + 8'h01) begin
      cfg(3'h3 + k[2:0], k[2:0] + 3'h1, {k[1:0], k[0] ^ k[1]}, ~k);
      put(8'h96 + k);
      wait_idle;
      chk(peer.sr, 8'h96 + k);
      pop(~k);
    end
  endtask
  task t_b2b;
    begin
      cfg(3'h1, 3'h2, 3'h2, 8'h5A);
      put(8'hC3);
      @(negedge i_clock);
      put(8'h3E);
      chk({7'h00, txe}, 8'h00);
      @(negedge i_clock);
      put(8'hF0);
      wait_idle;
      chk(peer.sr, 8'h3E);
      pop(8'h5A);
      pop(8'hC3);
      chk({7'h00, rxv}, 8'h00);
    end
  endtask
  // Receiver stalled: the fourth byte finds every stage full
  task t_overrun;
    begin
      cfg(3'h1, 3'h2, 3'h0, 8'h11);
      for (k = 8'h22; k < 8'h60; k = k + 8'h11) begin
        put(k);
        wait_idle;
      end
      chk({7'h00, rxf}, 8'h01);
      pop(8'h11);
      pop(8'h22);
      pop(8'h33);
      chk({6'h00, rxv, rxf}, 8'h00);
    end
  endtask
  // Bench as master, block as slave in phase 0, lines slower than sync
  task t_slave;
    integer i;
    reg [7:0] sv, got;
    begin
      sv = 8'h3C;
      got = 8'h00;
      mst = 1'b0;
      msck = 1'b0;
      {cpol, cpha, lsb} = 3'h0;
      repeat (8) @(negedge i_clock);
      put(8'hA5);
      ssn = 1'b0;
      repeat (8) @(negedge i_clock);
      chk({7'h00, mioe}, 8'h01);
      for (i = 7; i >= 0; i = i - 1) begin
        mmosi = sv[i];
        repeat (8) @(negedge i_clock);
        got[i] = mio;
        msck = 1'b1;
        repeat (8) @(negedge i_clock);
        msck = 1'b0;
      end
      repeat (8) @(negedge i_clock);
      ssn = 1'b1;
      chk(got, 8'hA5);
      pop(8'h3C);
      mst = 1'b1;
      msck = 1'b1;
      repeat (8) @(negedge i_clock);
    end
  endtask
  task t_disable;
    begin
      en = 1'b0;
      repeat (3) @(negedge i_clock);
      chk({5'h00, scoe, moe, mioe}, 8'h00);
      en = 1'b1;
    end
  endtask
  initial begin
    repeat (5) @(negedge i_clock);
    i_rst = 1'b0;
    @(negedge i_clock);
    t_reset;
    en = 1'b1;
    t_formats;
    t_b2b;
    t_overrun;
    t_slave;
    t_disable;
    test_done;
  end
endmodule
